// >>> dv/ept_checker.sv
// Checker for the prescaled timer: bus answers, read data, pin enable.
// Assumes binding to ept_timer; sees only its ports.
`timescale 1ns/10ps
module ept_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [ept_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic timer_pin_oe_n,
  input wire logic irq
);
  // ==========
  // Address of the read in flight, kept for judging its data
  logic [ept_pkg::ADDR_W-1:0] rd_addr;
  wire rd_mapped = rd_addr inside {ept_pkg::PRESCALER_ADDR, ept_pkg::COUNTER_ADDR,
    ept_pkg::STATUS_CONTROL_ADDR, ept_pkg::EVENT_STATUS_ADDR, ept_pkg::EVENT_MASK_ADDR};
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==========
  // Properties
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_reset_idle;
    $rose(aresetn) |-> !irq && timer_pin_oe_n && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  property p_wr_answer;
    s_wr_taken |=> !s_axi_awready && !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  property p_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_psc_top;
    s_axi_rvalid && rd_addr == ept_pkg::PRESCALER_ADDR |-> !s_axi_rdata[7];
  endproperty
  property p_rd_upper;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  property p_unmapped;
    s_axi_rvalid && !rd_mapped |-> s_axi_rresp == ept_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  // Direction only moves with a completed register write
  property p_oe_source;
    $changed(timer_pin_oe_n) |-> $rose(s_axi_bvalid);
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
  a_wr_answer: assert property (p_wr_answer) else $error("write response mistimed");
  a_rd_answer: assert property (p_rd_answer) else $error("read response mistimed");
  a_refuse: assert property (p_refuse) else $error("write taken while response pending");
  a_psc_top: assert property (p_psc_top) else $error("prescaler top bit not zero");
  a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits set");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  a_oe_source: assert property (p_oe_source) else $error("pin enable moved without write");
endmodule : ept_checker
bind ept_timer ept_checker i_ept_checker (.*);

// >>> dv/ept_pin_source.sv
// Signal source and load standing on the timer pin.
// Assumes the device drives the pin while its enable is low.
`timescale 1ns/10ps
module ept_pin_source (
  input wire logic drive_level,
  input wire logic pin_out,
  input wire logic pin_oe_n,
  output logic pin_in
);
  // ==========
  // Pin level
  // Push-pull output wins; a bench source pushing against it would be a short
  assign pin_in = pin_oe_n ? drive_level : pin_out;
endmodule : ept_pin_source

// >>> dv/tb.sv
// Self-checking bench for the prescaled timer, driven over its register bus.
// Assumes ept_pkg, ept_timer, the pin source model and the checker bind.
`timescale 1ns/10ps
module tb;
  // ==========
  // Signals; a short divider keeps the tap sweep brief
  localparam int DIV = 2;
  localparam logic [11:0] A_PS = ept_pkg::PRESCALER_ADDR;
  localparam logic [11:0] A_CT = ept_pkg::COUNTER_ADDR;
  localparam logic [11:0] A_SC = ept_pkg::STATUS_CONTROL_ADDR;
  localparam logic [11:0] A_ES = ept_pkg::EVENT_STATUS_ADDR;
  localparam logic [1:0] OK = ept_pkg::RESP_OKAY;
  localparam logic [1:0] SLV = ept_pkg::RESP_SLVERR;
  logic aclk = 1'h0, aresetn = 1'h0, src = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'h1;
  logic awready, wready, bvalid, arready, rvalid, pin_in, pin_out, oe_n, irq;
  logic [1:0] bresp, rresp;
  int failures = 0, samples_checked = 0, n, t, k;
  initial begin
    forever #5 aclk = ~aclk;
  end
  ept_timer #(.DIVIDE(DIV)) i_ept_timer (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer_pin_in(pin_in), .timer_pin_out(pin_out), .timer_pin_oe_n(oe_n), .irq(irq));
  ept_pin_source i_ept_pin_source (.drive_level(src), .pin_out(pin_out), .pin_oe_n(oe_n),
    .pin_in(pin_in));
  // ==========
  // Verdict and comparisons
  task automatic complete_run;
    $display("Checks %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic check_range(input string what, input logic [31:0] lo, hi, got);
    samples_checked++;
    if ((got >= lo && got <= hi) !== 1'h1) begin
      failures++;
      $display("CHECK FAILED %s expected %h..%h seen %h", what, lo, hi, got);
    end
  endtask : check_range
  task automatic wait_cyc(input int c);
    repeat (c) @(posedge aclk);
    #1;
  endtask : wait_cyc
  // ==========
  // Bus cycles: each channel released at the edge that takes it
  task automatic bus_write(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_go, w_go, b_go;
    b_go = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 50 && !b_go; n++) begin
      @(negedge aclk);
      aw_go = awvalid && awready;
      w_go = wvalid && wready;
      b_go = bvalid && bready;
      if (b_go) check("write response", {30'h0, er}, {30'h0, bresp});
      @(posedge aclk);
      if (aw_go) awvalid <= 1'h0;
      if (w_go) wvalid <= 1'h0;
      if (b_go) bready <= 1'h0;
    end
    if (!b_go) begin
      failures++;
      complete_run();
    end
  endtask : bus_write
  task automatic bus_read(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
    logic ar_go, r_go;
    r_go = 1'h0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 50 && !r_go; n++) begin
      @(negedge aclk);
      ar_go = arvalid && arready;
      r_go = rvalid && rready;
      d = rdata;
      if (r_go) check("read response", {30'h0, er}, {30'h0, rresp});
      @(posedge aclk);
      if (ar_go) arvalid <= 1'h0;
      if (r_go) rready <= 1'h0;
    end
    if (!r_go) begin
      failures++;
      complete_run();
    end
  endtask : bus_read
  task automatic read_check(input string what, input logic [11:0] a, input logic [31:0] exp);
    bus_read(a, OK, rd);
    check(what, exp, rd);
  endtask : read_check
  // ==========
  // Scenarios
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    read_check("prescaler reset", A_PS, 32'h7f);
    read_check("counter reset", A_CT, 32'hff);
    read_check("control reset", A_SC, 32'h0);
    check("pin enable reset", 32'h1, {31'h0, oe_n});
    bus_read(12'h35c, SLV, rd);
    bus_write(12'h35c, 8'h55, SLV);
    // Init bit low: prescaler pinned, counter frozen but writable
    bus_write(A_PS, 8'h10, OK);
    read_check("prescaler held", A_PS, 32'h7f);
    bus_write(A_CT, 8'h5a, OK);
    wait_cyc(40);
    read_check("counter frozen", A_CT, 32'h5a);
    // A write with its low strobe off must leave the counter alone
    wstrb <= 4'h0;
    bus_write(A_CT, 8'h11, OK);
    read_check("strobe off ignored", A_CT, 32'h5a);
    wstrb <= 4'h1;
    // Every tap in output mode: eight counter ticks expected per window
    for (t = 0; t < 8; t++) begin
      bus_write(A_SC, {5'h04, t[2:0]}, OK);
      check("pin driven", 32'h0, {31'h0, oe_n});
      bus_write(A_CT, 8'hff, OK);
      bus_write(A_SC, {5'h05, t[2:0]}, OK);
      wait_cyc((DIV * 8) << t);
      bus_read(A_CT, OK, rd);
      check_range("counter ticks", 32'hf4, 32'hf8, rd);
      bus_read(A_PS, OK, rd);
      check("prescaler top bit", 32'h0, {24'h0, rd[7], 7'h0});
    end
    // Underflow sets the flag and latches the output bit onto the pin
    check("pin before", 32'h0, {31'h0, pin_out});
    bus_write(A_SC, 8'h38, OK);
    bus_write(A_CT, 8'h03, OK);
    rd = 32'h0;
    for (k = 0; k < 20 && rd[7] !== 1'h1; k++) bus_read(A_SC, OK, rd);
    check("zero flag", 32'h1, {31'h0, rd[7]});
    wait_cyc(2);
    check("pin latched", 32'h1, {31'h0, pin_out});
    read_check("underflow event", A_ES, 32'h1);
    read_check("event cleared", A_ES, 32'h0);
    bus_read(A_CT, OK, rd);
    check_range("counter reload", 32'he0, 32'hff, rd);
    // Interrupt follows enable and flag
    bus_write(A_SC, 8'h80, OK);
    wait_cyc(2);
    check("irq masked", 32'h0, {31'h0, irq});
    bus_write(A_SC, 8'hc0, OK);
    wait_cyc(2);
    check("irq raised", 32'h1, {31'h0, irq});
    wait_cyc(50);
    read_check("flag sticky", A_SC, 32'hc0);
    bus_write(A_SC, 8'h40, OK);
    wait_cyc(2);
    check("irq cleared", 32'h0, {31'h0, irq});
    bus_write(A_CT, 8'h00, OK);
    wait_cyc(2);
    check("irq on zero write", 32'h1, {31'h0, irq});
    // Gated input: counts only while the pin is high
    bus_write(A_SC, 8'h18, OK);
    bus_write(A_CT, 8'hff, OK);
    wait_cyc(60);
    read_check("gated low", A_CT, 32'hff);
    @(posedge aclk);
    src <= 1'h1;
    wait_cyc(40);
    bus_read(A_CT, OK, rd);
    check_range("gated high", 32'he8, 32'hee, rd);
    @(posedge aclk);
    src <= 1'h0;
    // Event counting: five rising pin edges, one tick each, masked-in edge event
    bus_write(A_SC, 8'h08, OK);
    bus_write(A_CT, 8'hff, OK);
    bus_write(ept_pkg::EVENT_MASK_ADDR, 8'h02, OK);
    bus_read(A_ES, OK, rd);
    for (k = 0; k < 10; k++) begin
      repeat (4) @(posedge aclk);
      src <= ~src;
    end
    wait_cyc(6);
    read_check("edge count", A_CT, 32'hfa);
    check("irq on edge", 32'h1, {31'h0, irq});
    read_check("edge event", A_ES, 32'h2);
    wait_cyc(2);
    check("irq after clear", 32'h0, {31'h0, irq});
    // Counter written to 01h, then one pin edge takes it down to zero
    bus_write(A_CT, 8'h01, OK);
    @(posedge aclk);
    src <= 1'h1;
    wait_cyc(4);
    @(posedge aclk);
    src <= 1'h0;
    wait_cyc(4);
    read_check("counter at zero", A_CT, 32'h00);
    // Edge set one cycle before the write starts: the synchronised rise
    // and the held write meet in the same cycle
    @(posedge aclk);
    src <= 1'h1;
    bus_write(A_CT, 8'h40, OK);
    read_check("write beats underflow", A_SC, 32'h08);
    read_check("written count kept", A_CT, 32'h40);
    complete_run();
  end
endmodule : tb

// >>> hdl/ept_sync.sv
// Two-stage synchroniser with rising-edge detector for the timer pin.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module ept_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic async_in,
  output logic level,
  output logic rise
);

  // ==========================================================
  // Synchroniser
  logic stage1;
  logic stage2;
  logic stage3;

  // Only stage2 reads stage1; the edge detector looks at later stages
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Level and one-cycle rising pulse
  assign level = stage2;
  assign rise = stage2 & ~stage3;

endmodule : ept_sync

// >>> hdl/ept_timer.sv
// Prescaled 8-bit down timer with AXI4-Lite register slave.
// Assumes aclk is the internal clock; the timer pin is external and is
// synchronised here before use.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps

// Functional notes
// - Underflow from 00h to FFh sets zero flag
// - Interrupt when enable and zero flag set
// - Prescaler reads zero in top bit
// - Counter resets to FFh, always accessible
// - Prescaler resets to 7Fh
// - Status/control resets to all zeros
// - Status/control bit layout fixed
// - Direction bit chooses input or push-pull output
// - Output data latched on flag rise
// - Init bit low forces 7Fh, freezes counter
// - Init bit high lets both run
// - Tap select divides by two to n
// - Prescaler reloads 7Fh at zero
// - Counter decrements per tap, reloads FFh
// - Gated mode counts divided clock while pin high
// - Counter write beats decrement to zero
module ept_timer #(
  parameter int DIVIDE = ept_pkg::INT_DIVIDE
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ept_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ept_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_pin_in,
  output logic timer_pin_out,
  output logic timer_pin_oe_n,
  output logic irq
);

  // ==========================================================
  // Decode helpers
  // Low bits of the prescaler that must be zero for a counter tick
  function automatic logic [ept_pkg::PRESC_W-1:0] tap_mask(input logic [2:0] sel);
    tap_mask = ept_pkg::PRESC_W'((8'h01 << sel) - 8'h01);
  endfunction : tap_mask

  // Register address match, used by both write and read paths
  function automatic logic addr_is(input logic [ept_pkg::ADDR_W-1:0] a,
                                   input logic [ept_pkg::ADDR_W-1:0] r);
    addr_is = (a == r);
  endfunction : addr_is

  // ==========================================================
  // State
  ept_pkg::ept_ctrl_type ctrl;
  ept_pkg::ept_ctrl_type next_ctrl;
  logic [ept_pkg::PRESC_W-1:0] prescaler;
  logic [ept_pkg::PRESC_W-1:0] next_prescaler;
  logic [ept_pkg::COUNT_W-1:0] counter;
  logic [ept_pkg::COUNT_W-1:0] next_counter;
  logic [ept_pkg::EVENT_W-1:0] event_status;
  logic [ept_pkg::EVENT_W-1:0] next_event_status;
  logic [ept_pkg::EVENT_W-1:0] event_mask;
  logic [3:0] div_count;
  logic flag_prev;
  logic pin_latch;

  // AXI write capture
  ept_pkg::ept_wreq_type wreq;
  logic aw_held;
  logic w_held;

  // ==========================================================
  // Pin synchroniser
  logic pin_level;
  logic pin_rise;

  ept_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(timer_pin_in),
    .level(pin_level),
    .rise(pin_rise)
  );

  // ==========================================================
  // AXI write channel
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire wr_fire = aw_held & w_held & ~s_axi_bvalid;
  wire wr_en = wr_fire & wreq.strb;
  wire wr_psc = wr_en & addr_is(wreq.addr, ept_pkg::PRESCALER_ADDR);
  wire wr_cnt = wr_en & addr_is(wreq.addr, ept_pkg::COUNTER_ADDR);
  wire wr_sc = wr_en & addr_is(wreq.addr, ept_pkg::STATUS_CONTROL_ADDR);
  wire wr_msk = wr_en & addr_is(wreq.addr, ept_pkg::EVENT_MASK_ADDR);
  wire wr_mapped = addr_is(wreq.addr, ept_pkg::PRESCALER_ADDR)
                 | addr_is(wreq.addr, ept_pkg::COUNTER_ADDR)
                 | addr_is(wreq.addr, ept_pkg::STATUS_CONTROL_ADDR)
                 | addr_is(wreq.addr, ept_pkg::EVENT_STATUS_ADDR)
                 | addr_is(wreq.addr, ept_pkg::EVENT_MASK_ADDR);

  // Each channel is taken once, then held until the response drains
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;

  // Capture address and data independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wreq <= '0;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        wreq.addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (w_take) begin
        w_held <= 1'b1;
        wreq.data <= s_axi_wdata[7:0];
        wreq.strb <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ept_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? ept_pkg::RESP_OKAY : ept_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // AXI read channel
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire rd_psc = addr_is(s_axi_araddr, ept_pkg::PRESCALER_ADDR);
  wire rd_cnt = addr_is(s_axi_araddr, ept_pkg::COUNTER_ADDR);
  wire rd_sc = addr_is(s_axi_araddr, ept_pkg::STATUS_CONTROL_ADDR);
  wire rd_evt = addr_is(s_axi_araddr, ept_pkg::EVENT_STATUS_ADDR);
  wire rd_msk = addr_is(s_axi_araddr, ept_pkg::EVENT_MASK_ADDR);
  wire rd_mapped = rd_psc | rd_cnt | rd_sc | rd_evt | rd_msk;
  wire evt_clear = ar_take & rd_evt;

  // Read data mux; narrow registers sit in the low bits
  logic [7:0] rd_byte;
  assign rd_byte = rd_psc ? {1'b0, prescaler}
                 : rd_cnt ? counter
                 : rd_sc ? ctrl
                 : rd_evt ? {6'h00, event_status}
                 : rd_msk ? {6'h00, event_mask}
                 : 8'h00;

  assign s_axi_arready = ~s_axi_rvalid;

  // Data registered on the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ept_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= rd_mapped ? ept_pkg::RESP_OKAY : ept_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Internal clock divided by DIVIDE (twelve by default), as a one-cycle enable
  wire div_pulse = (div_count == 4'(DIVIDE - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_count <= 4'h0;
    end else begin
      div_count <= div_pulse ? 4'h0 : div_count + 4'h1;
    end
  end

  // ==========================================================
  // Prescaler input selection by mode
  ept_pkg::ept_mode_type mode;
  logic pre_pulse;

  assign mode = ept_pkg::ept_mode_type'({ctrl.pin_direction, ctrl.output_data});

  // Event mode counts pin edges; gated mode needs the pin high
  always_comb begin
    case (mode)
      ept_pkg::EPT_EVENT_COUNT: pre_pulse = pin_rise;
      ept_pkg::EPT_GATED: pre_pulse = div_pulse & pin_level;
      ept_pkg::EPT_OUT_LOW: pre_pulse = div_pulse;
      ept_pkg::EPT_OUT_HIGH: pre_pulse = div_pulse;
      default: pre_pulse = 1'b0;
    endcase
  end

  // ==========================================================
  // Prescaler and counter tick
  wire run = ctrl.prescaler_init;
  wire presc_zero = (prescaler == '0);
  wire tap_hit = ((prescaler & tap_mask(ctrl.tap_select)) == '0);
  wire tick = pre_pulse & run & tap_hit;
  wire cnt_zero = (counter == ept_pkg::COUNT_ZERO);
  wire underflow = tick & cnt_zero & ~wr_cnt;

  // Direct prescaler writes are only honoured while running
  always_comb begin
    if (!run) begin
      next_prescaler = ept_pkg::PRESC_MAX;
    end else if (wr_psc) begin
      next_prescaler = wreq.data[ept_pkg::PRESC_W-1:0];
    end else if (pre_pulse) begin
      next_prescaler = presc_zero ? ept_pkg::PRESC_MAX : prescaler - 7'h01;
    end else begin
      next_prescaler = prescaler;
    end
  end

  // Software write has priority over the decrement
  always_comb begin
    if (wr_cnt) begin
      next_counter = wreq.data;
    end else if (tick) begin
      next_counter = cnt_zero ? ept_pkg::COUNT_MAX : counter - 8'h01;
    end else begin
      next_counter = counter;
    end
  end

  // ==========================================================
  // Status/control next value
  // The flag is set by underflow, a write of 00h to the counter, or a
  // write of one to bit 7; a set in the same cycle as a clear wins.
  wire flag_set = underflow | (wr_cnt & (wreq.data == ept_pkg::COUNT_ZERO))
                | (wr_sc & wreq.data[7]);
  wire flag_clr = wr_sc & ~wreq.data[7];

  always_comb begin
    next_ctrl = ctrl;
    if (wr_sc) begin
      next_ctrl = ept_pkg::ept_ctrl_type'(wreq.data);
    end
    if (flag_set) begin
      next_ctrl.zero_flag = 1'b1;
    end else if (flag_clr) begin
      next_ctrl.zero_flag = 1'b0;
    end else begin
      next_ctrl.zero_flag = ctrl.zero_flag;
    end
  end

  // ==========================================================
  // Sticky events; a new event beats the read clear
  wire [ept_pkg::EVENT_W-1:0] evt_in = {pin_rise & ~ctrl.pin_direction, underflow};

  assign next_event_status = (evt_clear ? '0 : event_status) | evt_in;

  // ==========================================================
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescaler <= ept_pkg::PRESC_MAX;
      counter <= ept_pkg::COUNT_MAX;
      ctrl <= ept_pkg::STATUS_CONTROL_RESET;
      event_status <= ept_pkg::EVENT_RESET;
      event_mask <= ept_pkg::EVENT_RESET;
    end else begin
      prescaler <= next_prescaler;
      counter <= next_counter;
      ctrl <= next_ctrl;
      event_status <= next_event_status;
      if (wr_msk) begin
        event_mask <= wreq.data[ept_pkg::EVENT_W-1:0];
      end
    end
  end

  // ==========================================================
  // Pin output latch
  // Output data is captured only on the flag's rising edge, so later
  // writes to the data bit do not reach the pin until the flag next rises.
  wire flag_rise = ctrl.zero_flag & ~flag_prev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_prev <= 1'b0;
      pin_latch <= 1'b0;
    end else begin
      flag_prev <= ctrl.zero_flag;
      if (flag_rise) begin
        pin_latch <= ctrl.output_data;
      end
    end
  end

  // Push-pull drive in output mode; enable is active low
  assign timer_pin_out = pin_latch;
  assign timer_pin_oe_n = ~ctrl.pin_direction;

  // ==========================================================
  // Interrupt output, registered to keep it glitch free
  wire timer_req = ctrl.irq_enable & ctrl.zero_flag;
  wire evt_req = |(event_status & event_mask);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= timer_req | evt_req;
    end
  end

endmodule : ept_timer

// >>> inc/ept_pkg.sv
// Package for the prescaled 8-bit down timer: register map, field layout,
// reset values and timing counts.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package ept_pkg;

  // ==========================================================
  // Register indices and byte addresses
  localparam int ADDR_W = 12;
  localparam logic [7:0] PRESCALER_IDX = 8'hd2;
  localparam logic [7:0] COUNTER_IDX = 8'hd3;
  localparam logic [7:0] STATUS_CONTROL_IDX = 8'hd4;
  localparam logic [7:0] EVENT_STATUS_IDX = 8'hd5;
  localparam logic [7:0] EVENT_MASK_IDX = 8'hd6;
  localparam logic [ADDR_W-1:0] PRESCALER_ADDR = {2'h0, PRESCALER_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] COUNTER_ADDR = {2'h0, COUNTER_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] STATUS_CONTROL_ADDR = {2'h0, STATUS_CONTROL_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] EVENT_STATUS_ADDR = {2'h0, EVENT_STATUS_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] EVENT_MASK_ADDR = {2'h0, EVENT_MASK_IDX, 2'h0};

  // ==========================================================
  // Widths and reset values
  localparam int PRESC_W = 7;
  localparam int COUNT_W = 8;
  localparam int EVENT_W = 2;
  localparam logic [PRESC_W-1:0] PRESC_MAX = 7'h7f;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 8'hff;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 8'h00;
  localparam logic [7:0] STATUS_CONTROL_RESET = 8'h00;
  localparam logic [EVENT_W-1:0] EVENT_RESET = 2'h0;

  // Event bit positions in the sticky status and mask registers
  localparam int EVT_UNDERFLOW = 0;
  localparam int EVT_PIN_EDGE = 1;

  // ==========================================================
  // Timing: the prescaler source is the system clock divided by twelve
  localparam int CLK_PERIOD_NS = 10;
  localparam int INT_DIVIDE = 12;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Status/control layout, most significant bit first
  typedef struct packed {
    logic zero_flag;
    logic irq_enable;
    logic pin_direction;
    logic output_data;
    logic prescaler_init;
    logic [2:0] tap_select;
  } ept_ctrl_type;

  // Captured write request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
    logic strb;
  } ept_wreq_type;

  // Operating mode from pin direction and output data
  typedef enum logic [1:0] {
    EPT_EVENT_COUNT = 2'b00,
    EPT_GATED = 2'b01,
    EPT_OUT_LOW = 2'b10,
    EPT_OUT_HIGH = 2'b11
  } ept_mode_type;

endpackage : ept_pkg
